// [logic/adc_map_port_pin_logic.sv]
// Operation
// - Decode the window: nine register words, 40 command words, 120 result words.
// - Global registers are always supervisor-only.
// - Other registers and tables may be assigned to user space.
// - Unused channel pins serve as digital port bits via port data.
// - Port A bits follow their direction bits for read and drive, except trigger pins and mux address pins.
// - Port A only pulls low; it releases the pin otherwise.
// - Port B is input only, read through port data.
// - Port A input reads return a synchronized pin sample.
// - Command table: 40 words, ten implemented bits.
// - Results readable right, left signed and left unsigned.
// - Separate queue controls; status shows queues and current conversion.
// - Triggers share port A bits 3 and 4, one per queue.
// - Trigger mode forces its pin to input, ignoring direction.
// - Non-multiplexed mode routes all 16 pins to the converter.
// - Multiplexed mode drives a 3-bit external mux address.
// - Mux address pins are outputs in mux mode, else general I/O.
// - Four port B inputs carry the even/odd low/high channel groups.
// - Channel numbering covers up to 41 channels with external muxing.
// - Output bits read back the latch, not the pin.
`default_nettype none
module adc_map_port_pin_logic
    import adc_map_pkg::*;
#(
    parameter int NTAB = N_TAB
) (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [31:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [2:0] pprot, // APB protection
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] port_a_in, // Port A pin level
    output logic [7:0] port_a_out, // Port A drive value
    output logic [7:0] port_a_oe, // Port A pull-low enable
    input wire logic [7:0] port_b_in, // Port B pin level
    input wire conv_stat_s conv_stat, // Sequencer state
    input wire res_wr_s res_wr, // Result write
    input wire logic [5:0] ccw_rd_idx, // Command read index
    output logic [9:0] ccw_rd_data, // Command word
    output logic [1:0] external_trigger_inputs, // Synced triggers
    output logic [2:0] ext_mux_select_outputs, // Mux address
    output logic [3:0] conv_pin, // Analog pin select
    output logic ext_mux_mode // Mux mode active
);
    function automatic logic [15:0] fmt_res(input logic [9:0] r, input logic [1:0] f);
        logic [15:0] v;
        v = {6'h00, r};
        if (f == 2'h1) begin
            v = {~r[9], r[8:0], 6'h00};
        end else if (f == 2'h2) begin
            v = {r, 6'h00};
        end
        return v;
    endfunction : fmt_res

    function automatic logic in_tab(input logic [7:0] i, input logic [7:0] b);
        return (i >= b) && (i < b + 8'(NTAB));
    endfunction : in_tab

    logic rs1_q, rst_s_n;
    logic [7:0] pa1_q, pa_q, pb1_q, pb_q;
    logic [15:0] mcr_q, test_q, int_q, cr0_q, cr1_q, cr2_q;
    logic [7:0] pa_lat_q, dir_q;
    logic [9:0] ccw_mem [NTAB];
    logic [9:0] res_mem [NTAB];
    logic [31:0] prdata_q;
    logic pready_q;
    logic [7:0] oe_q;
    logic [2:0] ma_q;
    logic [3:0] pin_q;
    logic [1:0] trig_q;
    logic mux_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_s_n <= rs1_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pa1_q <= 8'h00;
            pa_q <= 8'h00;
            pb1_q <= 8'h00;
            pb_q <= 8'h00;
        end else begin
            pa1_q <= port_a_in;
            pa_q <= pa1_q;
            pb1_q <= port_b_in;
            pb_q <= pb1_q;
        end
    end

    wire in_win = paddr[31:10] == 22'h000000;
    wire [7:0] widx = paddr[9:2];
    wire priv = pprot[0];
    wire acc = psel && penable && !pready_q;
    wire hit_glb = in_win && (widx <= INT_IDX);
    wire hit_reg = in_win && (widx > INT_IDX) && (widx <= STAT_IDX);
    wire hit_ccw = in_win && in_tab(widx, CCW_BASE);
    wire hit_rr = in_win && in_tab(widx, RES_R_BASE);
    wire hit_rs = in_win && in_tab(widx, RES_LS_BASE);
    wire hit_ru = in_win && in_tab(widx, RES_LU_BASE);
    wire hit_res = hit_rr || hit_rs || hit_ru;
    wire hit_asg = hit_reg || hit_ccw || hit_res;
    wire glb_ok = hit_glb && priv;
    wire asg_ok = hit_asg && (priv || !mcr_q[MCR_SUPV_BIT]);
    // Writes land at the edge that completes the transfer
    wire wr_ok = psel && penable && pready_q && pwrite && (glb_ok || asg_ok);
    wire [7:0] ccw_off = widx - CCW_BASE;
    wire [7:0] res_base = hit_rr ? RES_R_BASE : (hit_rs ? RES_LS_BASE : RES_LU_BASE);
    wire [7:0] res_off = widx - res_base;
    wire [1:0] res_fmt = hit_rr ? 2'h0 : (hit_rs ? 2'h1 : 2'h2);

    wire q1_ext = cr1_q[CR_ETRIG_BIT];
    wire q2_ext = cr2_q[CR_ETRIG_BIT];
    wire mux_on = cr0_q[CR0_MUX_BIT];
    wire [5:0] chan = conv_stat.chan;
    wire [7:0] trig_mask = (8'(q1_ext) << TRIG1_PIN) | (8'(q2_ext) << TRIG2_PIN);
    wire [7:0] mux_mask = mux_on ? 8'h07 : 8'h00;
    wire [7:0] dir_eff = (dir_q & ~trig_mask) | mux_mask;
    wire [2:0] ma_d = chan[3:1];
    wire [7:0] drive_val = mux_on ? {pa_lat_q[7:3], ma_d} : pa_lat_q;
    // Latch for outputs, pin for inputs
    wire [7:0] pa_rd = (pa_lat_q & dir_eff) | (pa_q & ~dir_eff);
    wire [3:0] pin_mux = {2'h0, chan[4], chan[0]};
    wire [3:0] pin_d = mux_on && (chan < 6'd32) ? pin_mux : chan[3:0];

    logic [15:0] reg_rd;
    always_comb begin
        reg_rd = 16'h0000;
        unique case (widx)
            MCR_IDX: reg_rd = mcr_q;
            TEST_IDX: reg_rd = test_q;
            INT_IDX: reg_rd = int_q;
            PORT_IDX: reg_rd = {pa_rd, pb_q};
            DIR_IDX: reg_rd = {8'h00, dir_q};
            CR0_IDX: reg_rd = cr0_q;
            CR1_IDX: reg_rd = cr1_q;
            CR2_IDX: reg_rd = cr2_q;
            STAT_IDX: reg_rd = {6'h00, conv_stat};
            default: reg_rd = 16'h0000;
        endcase
    end

    logic [15:0] rd16;
    always_comb begin
        rd16 = 16'h0000;
        if (hit_asg && !asg_ok) begin
            rd16 = USER_DENY;
        end else if (glb_ok || hit_reg) begin
            rd16 = reg_rd;
        end else if (hit_ccw) begin
            rd16 = {6'h00, ccw_mem[ccw_off[5:0]]};
        end else if (hit_res) begin
            rd16 = fmt_res(res_mem[res_off[5:0]], res_fmt);
        end
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= acc;
            if (acc && !pwrite) begin
                prdata_q <= {16'h0000, rd16};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            mcr_q <= MCR_RST;
            test_q <= REG_RST;
            int_q <= REG_RST;
            cr0_q <= REG_RST;
            cr1_q <= REG_RST;
            cr2_q <= REG_RST;
            pa_lat_q <= 8'h00;
            dir_q <= 8'h00;
        end else if (wr_ok) begin
            if (widx == MCR_IDX) mcr_q <= pwdata[15:0];
            if (widx == TEST_IDX) test_q <= pwdata[15:0];
            if (widx == INT_IDX) int_q <= pwdata[15:0];
            if (widx == PORT_IDX) pa_lat_q <= pwdata[15:8];
            if (widx == DIR_IDX) dir_q <= pwdata[7:0];
            if (widx == CR0_IDX) cr0_q <= pwdata[15:0];
            if (widx == CR1_IDX) cr1_q <= pwdata[15:0];
            if (widx == CR2_IDX) cr2_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_ok && hit_ccw) begin
            ccw_mem[ccw_off[5:0]] <= pwdata[9:0];
        end
        if (res_wr.en && (res_wr.idx < 6'(NTAB))) begin
            res_mem[res_wr.idx] <= res_wr.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            oe_q <= 8'h00;
            ma_q <= 3'h0;
            pin_q <= 4'h0;
            trig_q <= 2'h0;
            mux_q <= 1'b0;
            ccw_rd_data <= 10'h000;
        end else begin
            oe_q <= dir_eff & ~drive_val;
            ma_q <= ma_d;
            pin_q <= pin_d;
            trig_q <= {pa_q[TRIG2_PIN], pa_q[TRIG1_PIN]};
            mux_q <= mux_on;
            ccw_rd_data <= ccw_mem[ccw_rd_idx];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = 1'b0;
    assign port_a_out = 8'h00;
    assign port_a_oe = oe_q;
    assign external_trigger_inputs = trig_q;
    assign ext_mux_select_outputs = ma_q;
    assign conv_pin = pin_q;
    assign ext_mux_mode = mux_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_s_n);

    sequence s_rd_req;
        acc && !pwrite;
    endsequence

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_first_access;
        psel && penable && !pready;
    endsequence

    sequence s_wr_done;
        psel && penable && pready && pwrite;
    endsequence

    a_ready_one_wait: assert property (acc |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_glb_user_zero: assert property (s_rd_req and hit_glb && !priv |=> prdata == 32'h0)
        else $error("user global read not zero");
    a_asg_user_deny: assert property (
        s_rd_req and hit_asg && !priv && mcr_q[MCR_SUPV_BIT] |=> prdata == 32'h0000ffff)
        else $error("denied read not ffff");
    a_rsvd_zero: assert property (
        s_rd_req and !(hit_glb || hit_asg) |=> prdata == 32'h0)
        else $error("reserved read not zero");
    a_trig_input: assert property (q1_ext [*2] |-> !port_a_oe[TRIG1_PIN])
        else $error("trigger pin driven");
    a_mux_addr: assert property (
        $stable(chan) |=> ext_mux_select_outputs == $past(chan[3:1]))
        else $error("mux address wrong");
    a_portb_read: assert property (
        s_rd_req and widx == PORT_IDX && asg_ok |=> prdata[7:0] == $past(pb_q))
        else $error("port b read wrong");
    a_od_drive: assert property (
        $past(dir_eff[0]) && !$past(drive_val[0]) |-> port_a_oe[0] && port_a_out[0] == 1'b0)
        else $error("open drain drive wrong");
    a_setup_answer: assert property (s_setup ##1 s_first_access |=> pready)
        else $error("no answer after access");
    a_glb_user_write: assert property (
        s_wr_done and hit_glb && !priv |=> $stable(mcr_q) && $stable(test_q) && $stable(int_q))
        else $error("user global write landed");
    a_asg_user_write: assert property (
        s_wr_done and hit_asg && !priv && mcr_q[MCR_SUPV_BIT]
        |=> $stable(dir_q) && $stable(pa_lat_q) && $stable(cr0_q) && $stable(cr1_q))
        else $error("denied user write landed");
    a_user_write_ok: assert property (
        s_wr_done and widx == DIR_IDX && asg_ok |=> dir_q == $past(pwdata[7:0]))
        else $error("direction write lost");
    a_rsvd_write: assert property (
        s_wr_done and !(hit_glb || hit_asg)
        |=> $stable(mcr_q) && $stable(dir_q) && $stable(pa_lat_q) && $stable(cr0_q))
        else $error("reserved write landed");
    a_trig2_input: assert property (q2_ext [*2] |-> !port_a_oe[TRIG2_PIN])
        else $error("trigger two pin driven");
    a_mux_pin_drive: assert property (
        mux_on |=> port_a_oe[2:0] == ~$past(chan[3:1]))
        else $error("mux pins not driven");
    a_group_pin: assert property (
        mux_on && chan < 6'd32 |=> conv_pin == {2'b00, $past(chan[4]), $past(chan[0])})
        else $error("group pin wrong");
    a_direct_pin: assert property (!mux_on |=> conv_pin == $past(chan[3:0]))
        else $error("direct pin wrong");
    a_out_latch_read: assert property (
        s_rd_req and widx == PORT_IDX && asg_ok
        |=> (prdata[15:8] & $past(dir_eff)) == ($past(pa_lat_q) & $past(dir_eff)))
        else $error("output bit not latch");
    a_in_pin_read: assert property (
        s_rd_req and widx == PORT_IDX && asg_ok
        |=> (prdata[15:8] & ~$past(dir_eff)) == ($past(pa_q) & ~$past(dir_eff)))
        else $error("input bit not pin");
    a_trig_follow: assert property (
        external_trigger_inputs == $past({pa_q[TRIG2_PIN], pa_q[TRIG1_PIN]}))
        else $error("trigger pins wrong");
    a_ccw_ten_bits: assert property (
        s_rd_req and hit_ccw && asg_ok |=> prdata[15:10] == 6'h00)
        else $error("command word upper bits set");
    a_res_low_zero: assert property (
        s_rd_req and (hit_rs || hit_ru) && asg_ok |=> prdata[5:0] == 6'h00)
        else $error("left result low bits set");
    a_stat_read: assert property (
        s_rd_req and widx == STAT_IDX && asg_ok |=> prdata[9:0] == $past(conv_stat))
        else $error("status read wrong");
endmodule : adc_map_port_pin_logic
`default_nettype wire

// [pkg/adc_map_pkg.sv]
`default_nettype none
package adc_map_pkg;
    localparam int WIDX_W = 8;
    localparam int N_TAB = 40;
    localparam int RES_W = 10;
    localparam logic [7:0] MCR_IDX = 8'h00;
    localparam logic [7:0] TEST_IDX = 8'h01;
    localparam logic [7:0] INT_IDX = 8'h02;
    localparam logic [7:0] PORT_IDX = 8'h03;
    localparam logic [7:0] DIR_IDX = 8'h04;
    localparam logic [7:0] CR0_IDX = 8'h05;
    localparam logic [7:0] CR1_IDX = 8'h06;
    localparam logic [7:0] CR2_IDX = 8'h07;
    localparam logic [7:0] STAT_IDX = 8'h08;
    localparam logic [7:0] CCW_BASE = 8'h40;
    localparam logic [7:0] RES_R_BASE = 8'h80;
    localparam logic [7:0] RES_LS_BASE = 8'ha8;
    localparam logic [7:0] RES_LU_BASE = 8'hd0;
    localparam int MCR_SUPV_BIT = 7;
    localparam int CR0_MUX_BIT = 15;
    localparam int CR_ETRIG_BIT = 8;
    localparam int TRIG1_PIN = 3;
    localparam int TRIG2_PIN = 4;
    localparam logic [15:0] MCR_RST = 16'h0080;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [15:0] USER_DENY = 16'hffff;
    typedef struct packed {
        logic [1:0] q1_state;
        logic [1:0] q2_state;
        logic [5:0] chan;
    } conv_stat_s;
    typedef struct packed {
        logic en;
        logic [5:0] idx;
        logic [9:0] data;
    } res_wr_s;
endpackage : adc_map_pkg
`default_nettype wire

// [verif/pin_partner.sv]
`default_nettype none
module pin_partner (
    input wire logic [7:0] port_a_oe, // Device pull-low enables
    input wire logic [7:0] ext_pull, // Far-side pull-low drivers
    output logic [7:0] port_a_in // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    assign port_a_in = ~(port_a_oe | ext_pull);
endmodule : pin_partner
`default_nettype wire

// [verif/test_adc_map_port_pin_logic.sv]
`default_nettype none
module test_adc_map_port_pin_logic
    import adc_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, mux, err;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [2:0] pprot, msel;
    logic [7:0] pa_in, pa_out, pa_oe, pb_in, ext_pull;
    logic [5:0] ccw_idx;
    logic [9:0] ccw_data;
    logic [1:0] trig;
    logic [3:0] cpin;
    conv_stat_s cs;
    res_wr_s rw;
    int fails = 0;
    int samples_checked = 0;
    adc_map_port_pin_logic i_adc_map_port_pin_logic (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
        .port_b_in(pb_in), .conv_stat(cs), .res_wr(rw), .ccw_rd_idx(ccw_idx),
        .ccw_rd_data(ccw_data), .external_trigger_inputs(trig),
        .ext_mux_select_outputs(msel), .conv_pin(cpin), .ext_mux_mode(mux)
    );
    pin_partner i_pin_partner (
        .port_a_oe(pa_oe), .ext_pull(ext_pull), .port_a_in(pa_in)
    );
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                       input logic sup);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {16'h0, d};
        pprot <= {2'b00, sup};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic rdc(input logic [7:0] idx, input logic sup, input logic [31:0] e);
        apb(1'b0, idx, 16'h0, sup);
        chk(r, e);
    endtask : rdc
    task automatic t_map();
        rdc(MCR_IDX, 1'b1, 32'h80);
        apb(1'b1, 8'h09, 16'h1234, 1'b1);
        rdc(8'h09, 1'b1, 32'h0);
        chk({31'h0, err}, 32'h0);
        rdc(8'h68, 1'b1, 32'h0);
        rdc(8'hf8, 1'b1, 32'h0);
        $display("test map done");
    endtask : t_map
    task automatic t_space();
        rdc(MCR_IDX, 1'b0, 32'h0);
        apb(1'b1, MCR_IDX, 16'h0, 1'b0);
        rdc(MCR_IDX, 1'b1, 32'h80);
        apb(1'b1, DIR_IDX, 16'h0055, 1'b0);
        rdc(DIR_IDX, 1'b0, 32'hffff);
        rdc(DIR_IDX, 1'b1, 32'h0);
        apb(1'b1, MCR_IDX, 16'h0, 1'b1);
        apb(1'b1, DIR_IDX, 16'h00a0, 1'b0);
        rdc(DIR_IDX, 1'b0, 32'ha0);
        $display("test space done");
    endtask : t_space
    task automatic t_port();
        pb_in <= 8'h5a;
        ext_pull <= 8'h0e;
        apb(1'b1, PORT_IDX, 16'h0200, 1'b1);
        apb(1'b1, DIR_IDX, 16'h0003, 1'b1);
        repeat (4) @(posedge core_clk);
        chk({24'h0, pa_oe}, 32'h01);
        chk({24'h0, pa_out}, 32'h0);
        rdc(PORT_IDX, 1'b1, 32'hf25a);
        ext_pull <= 8'h00;
        repeat (4) @(posedge core_clk);
        rdc(PORT_IDX, 1'b1, 32'hfe5a);
        $display("test port done");
    endtask : t_port
    task automatic t_trig();
        apb(1'b1, PORT_IDX, 16'h0, 1'b1);
        apb(1'b1, DIR_IDX, 16'h0018, 1'b1);
        repeat (3) @(posedge core_clk);
        chk({24'h0, pa_oe}, 32'h18);
        apb(1'b1, CR1_IDX, 16'h0100, 1'b1);
        apb(1'b1, CR2_IDX, 16'h0100, 1'b1);
        repeat (3) @(posedge core_clk);
        chk({24'h0, pa_oe}, 32'h0);
        ext_pull <= 8'h08;
        repeat (4) @(posedge core_clk);
        chk({30'h0, trig}, 32'h2);
        ext_pull <= 8'h10;
        repeat (4) @(posedge core_clk);
        chk({30'h0, trig}, 32'h1);
        ext_pull <= 8'h00;
        apb(1'b1, DIR_IDX, 16'h0, 1'b1);
        $display("test trigger done");
    endtask : t_trig
    task automatic t_mux();
        cs <= '{2'b01, 2'b10, 6'd13};
        apb(1'b1, CR0_IDX, 16'h8000, 1'b1);
        repeat (3) @(posedge core_clk);
        chk({24'h0, mux, msel, cpin}, 32'he1);
        chk({24'h0, pa_oe}, 32'h01);
        rdc(STAT_IDX, 1'b1, 32'h18d);
        cs.chan <= 6'd30;
        repeat (3) @(posedge core_clk);
        chk({24'h0, mux, msel, cpin}, 32'hf2);
        apb(1'b1, CR0_IDX, 16'h0, 1'b1);
        repeat (3) @(posedge core_clk);
        chk({24'h0, mux, msel, cpin}, 32'h7e);
        $display("test mux done");
    endtask : t_mux
    task automatic t_tables();
        apb(1'b1, CCW_BASE + 8'd39, 16'hffff, 1'b1);
        ccw_idx <= 6'd39;
        repeat (2) @(posedge core_clk);
        chk({22'h0, ccw_data}, 32'h3ff);
        rdc(CCW_BASE + 8'd39, 1'b1, 32'h3ff);
        rw <= '{1'b1, 6'd39, 10'h2a5};
        @(posedge core_clk);
        rw.en <= 1'b0;
        @(posedge core_clk);
        rdc(RES_R_BASE + 8'd39, 1'b1, 32'h2a5);
        rdc(RES_LS_BASE + 8'd39, 1'b1, 32'h2940);
        rdc(RES_LU_BASE + 8'd39, 1'b1, 32'ha940);
        apb(1'b1, RES_R_BASE + 8'd39, 16'h0, 1'b1);
        rdc(RES_R_BASE + 8'd39, 1'b1, 32'h2a5);
        $display("test tables done");
    endtask : t_tables
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
        {pb_in, ext_pull, ccw_idx} = '0;
        cs = '0;
        rw = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_map();
        t_space();
        t_port();
        t_trig();
        t_mux();
        t_tables();
        give_verdict();
    end
endmodule : test_adc_map_port_pin_logic
`default_nettype wire
